// [inc/iptr_pkg.sv]
package iptr_pkg;
    // register map, byte addresses
    localparam logic [15:0] TGT_BASE      = 16'h0800;
    localparam logic [15:0] NSAC_BASE     = 16'h0E00;
    localparam logic [15:0] ESPEND_BASE   = 16'h1600;
    localparam int          ESPEND_MAXREG = 32;
    localparam int          EXT_ID_BASE   = 4096;
    localparam int          BANKED_TGT    = 8;
    localparam int          NUM_PE        = 8;
    localparam int          FIELD_W       = 8;
    localparam int          GRANT_W       = 2;
    localparam logic [1:0]  GRANT_ROUTE   = 2'h3;
    localparam logic [31:0] ESPEND_RST    = 32'h0;
    localparam logic [31:0] NSAC_RST      = 32'h0;
    localparam logic [7:0]  TGT_RST       = 8'h0;
    // access decode result
    typedef enum logic [1:0] {
        IPTR_SEL_NONE   = 2'b00,
        IPTR_SEL_TGT    = 2'b01,
        IPTR_SEL_ESPEND = 2'b10,
        IPTR_SEL_NSAC   = 2'b11
    } iptr_sel_t;
endpackage : iptr_pkg

// [logic/iptr_regs.sv]
`timescale 1ns/1ps
// Overview of operation
// - pending bit reads pending state, zero writes ignored
// - write one sets pending, reads back one
// - repeat set harmless; pending survives input drop
// - reset clears all extended pending bits
// - extended bit at 0x1600 index, modulo bit
// - extended registers exist only when enabled, counted
// - extended bit reserved zero without affinity routing
// - secure extended bits hidden from nonsecure accesses
// - absent interrupts read zero, writes ignored
// - eight-bit target field, bit per interface
// - target byte at 0x0800 index, lane m mod 4
// - banked targets read-only, return reader identity
// - high-numbered reader sees banked targets as zero
// - retarget leaves active interrupts alone
// - removed interface loses pending, added becomes eligible
// - pending uses old or new targets, bounded
// - affinity routing makes target byte read zero
// - byte access; absent fields, interfaces read zero
// - fixed targets read-only; single PE reads zero
// - secure targets need secure access or grant
// - eight target registers per lines unit, common
// - first access control register banked per PE
// - two-bit grants reset zero, 0b11 adds routing
module iptr_regs
    import iptr_pkg::*;
#(
    parameter int LINES_COUNT   = 0,  // interrupt_lines_count
    parameter int EXT_COUNT     = 0,  // extended_range_count
    parameter bit EXT_FEATURE   = 1,  // extended_range_feature
    parameter int NUM_CPU_IF    = 8,
    parameter int NUM_IMPL_INTS = 64,
    parameter int NUM_FIXED     = 0   // low shared ids with fixed targets
) (
    input  wire logic        clk,
    input  wire logic        sys_rst,
    input  wire logic        req,
    input  wire logic        wr,
    input  wire logic [15:0] addr,
    input  wire logic [3:0]  be,
    input  wire logic [31:0] wdata,
    input  wire logic        nonsecure,
    input  wire logic [3:0]  pe_num,
    input  wire logic        security_disable,
    input  wire logic        extended_range_present,
    input  wire logic        affinity_route_s,
    input  wire logic        affinity_route_ns,
    input  wire logic        single_pe,
    input  wire logic [ESPEND_MAXREG*32-1:0] ext_secure,
    input  wire logic [ESPEND_MAXREG*32-1:0] ext_line,
    input  wire logic [ESPEND_MAXREG*32-1:0] ext_active,
    input  wire logic [255:0] grp_secure,
    input  wire logic [255:0] grant_route,
    output logic [31:0]      rdata,
    output logic             rvalid,
    output logic [ESPEND_MAXREG*32-1:0] ext_pending
);
    localparam int NTGT = 8 * (LINES_COUNT + 1);
    localparam int NID  = NTGT * 4;
    localparam int NEXT = (EXT_FEATURE ? EXT_COUNT + 1 : 0) * 32;

    // decode which group an address hits
    function automatic iptr_sel_t sel_of(input logic [15:0] a);
        if (a >= TGT_BASE && a < TGT_BASE + 16'(NTGT * 4))
            return IPTR_SEL_TGT;
        else if (a >= ESPEND_BASE && a < ESPEND_BASE + 16'(ESPEND_MAXREG*4))
            return IPTR_SEL_ESPEND;
        else if (a == NSAC_BASE)
            return IPTR_SEL_NSAC;
        else
            return IPTR_SEL_NONE;
    endfunction : sel_of

    iptr_sel_t   sel;
    logic [15:0] widx;
    logic        banked_pe_ok;
    logic [7:0]  tgt_mem [NID];
    logic [31:0] nsac_bank [NUM_PE];
    logic [7:0]  if_mask;
    logic        ext_route_on;

    assign sel          = sel_of(addr);
    assign widx         = (addr - (sel == IPTR_SEL_TGT ? TGT_BASE
                                                       : ESPEND_BASE)) >> 2;
    assign banked_pe_ok = pe_num < 4'(BANKED_TGT);
    assign if_mask      = 8'((9'h1 << NUM_CPU_IF) - 9'h1);
    // extended bits live only when the range is present and the feature is built
    assign ext_route_on = extended_range_present & EXT_FEATURE;

    // per extended bit: visible and writable for this access
    function automatic logic ext_ok(input int i);
        logic aff;
        aff = ext_secure[i] ? affinity_route_s : affinity_route_ns;
        return ext_route_on && i < NEXT && i < NUM_IMPL_INTS
            && aff
            && !(nonsecure && !security_disable && ext_secure[i]);
    endfunction : ext_ok

    // per target byte: reachable by this access
    function automatic logic tgt_ok(input int m);
        logic aff;
        aff = grp_secure[m] ? affinity_route_s : affinity_route_ns;
        return !single_pe && m < NUM_IMPL_INTS
            && !aff
            && !(nonsecure && !security_disable && grp_secure[m]
                 && !grant_route[m]);
    endfunction : tgt_ok

    // one flag per extended bit that this cycle's write may set; kept apart
    // from the latch so the checks below can see what a write asked for
    logic [ESPEND_MAXREG*32-1:0] set_hits;
    always_comb begin
        set_hits = '0;
        for (int i = 0; i < ESPEND_MAXREG*32; i++) begin
            // only ones written set; zeros do nothing
            set_hits[i] = req && wr && sel == IPTR_SEL_ESPEND
                && widx == 16'(i/32) && be[(i%32)/8] && wdata[i%32]
                && ext_ok(i);
        end
    end

    // extended set-pending; the latch keeps pending after the line drops
    logic [ESPEND_MAXREG*32-1:0] sw_pend;
    always_ff @(posedge clk) begin
        if (sys_rst)
            sw_pend <= '0;
        else
            sw_pend <= sw_pend | set_hits;
    end
    // pending is the latch or the asserted line; setting again is idle
    always_ff @(posedge clk) begin
        if (sys_rst)
            ext_pending <= '0;
        else
            ext_pending <= sw_pend | ext_line;
    end

    // shared target bytes; banked ones never stored
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            for (int m = 0; m < NID; m++)
                tgt_mem[m] <= TGT_RST;
        end else if (req && wr && sel == IPTR_SEL_TGT
                     && widx >= 16'(BANKED_TGT)) begin
            for (int l = 0; l < 4; l++) begin
                automatic int m = int'(widx) * 4 + l;
                if (m < NID && be[l] && tgt_ok(m)
                    && !(m - BANKED_TGT*4 < NUM_FIXED))
                    tgt_mem[m] <= wdata[l*8 +: 8] & if_mask;
            end
        end
    end

    // first access control register, one copy per processing element
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            for (int p = 0; p < NUM_PE; p++)
                nsac_bank[p] <= NSAC_RST;
        end else if (req && wr && sel == IPTR_SEL_NSAC && !security_disable
                     && !nonsecure && banked_pe_ok) begin
            for (int l = 0; l < 4; l++)
                if (be[l])
                    nsac_bank[pe_num[2:0]][l*8 +: 8] <= wdata[l*8 +: 8];
        end
    end

    // read mux, answer one cycle after the request
    logic [31:0] next_rdata;
    always_comb begin
        next_rdata = '0;
        case (sel)
            IPTR_SEL_ESPEND: begin
                for (int b = 0; b < 32; b++) begin
                    automatic int i = int'(widx) * 32 + b;
                    if (i < ESPEND_MAXREG*32 && ext_ok(i))
                        next_rdata[b] = ext_pending[i];
                end
            end
            IPTR_SEL_TGT: begin
                for (int l = 0; l < 4; l++) begin
                    automatic int m = int'(widx) * 4 + l;
                    if (m < NID && tgt_ok(m)) begin
                        if (widx < 16'(BANKED_TGT))
                            // reader identity; high pes read zero
                            next_rdata[l*8 +: 8] = banked_pe_ok
                                ? (8'h1 << pe_num[2:0]) & if_mask : 8'h0;
                        else
                            next_rdata[l*8 +: 8] = tgt_mem[m];
                    end
                end
            end
            IPTR_SEL_NSAC: begin
                if (!security_disable && !nonsecure && banked_pe_ok)
                    next_rdata = nsac_bank[pe_num[2:0]];
            end
            default: next_rdata = '0;
        endcase
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            rdata  <= '0;
            rvalid <= 1'b0;
        end else begin
            rdata  <= (req && !wr) ? next_rdata : 32'h0;
            rvalid <= req && !wr;
        end
    end

    // retargeting: no forwarded set is computed here; target bytes are only stored
    // and read back, so sending pending interrupts to old or new targets is left to
    // logic outside this block; active state is held by the interfaces and is not touched here.

    // a write of zeros must leave every latched bit where it was
    AST_EXT_ZERO_WRITE: assert property (
        @(posedge clk) disable iff (sys_rst)
        (req && wr && sel == IPTR_SEL_ESPEND && wdata == 32'h0)
        |=> $stable(sw_pend))
        else $error("zero write changed pending");
    // the edge after reset sees every latch and output cleared
    AST_RESET_CLEAR: assert property (
        @(posedge clk)
        $past(sys_rst) |-> sw_pend == '0)
        else $error("pending not cleared by reset");
    AST_RESET_OUTS: assert property (
        @(posedge clk)
        $past(sys_rst) |-> (ext_pending == '0 && rdata == 32'h0 && !rvalid))
        else $error("outputs not cleared by reset");
    // no latched bit ever falls outside reset
    AST_PEND_STICKY: assert property (
        @(posedge clk) disable iff (sys_rst)
        1'b1 |=> (sw_pend & $past(sw_pend)) == $past(sw_pend))
        else $error("pending latch dropped");
    // an asserted line shows as pending one cycle later
    AST_PEND_LINE: assert property (
        @(posedge clk) disable iff (sys_rst)
        1'b1 |=> ($past(ext_line) & ~ext_pending) == '0)
        else $error("asserted line not pending");
    // a permitted one-write lands on the next edge
    AST_SET_LANDS: assert property (
        @(posedge clk) disable iff (sys_rst)
        (set_hits != '0) |=> (sw_pend & $past(set_hits)) == $past(set_hits))
        else $error("set-pending write lost");
    // without the extended range nothing may be latched by a write
    AST_EXT_HIDDEN_WRITE: assert property (
        @(posedge clk) disable iff (sys_rst)
        (req && wr && sel == IPTR_SEL_ESPEND && !ext_route_on)
        |=> $stable(sw_pend))
        else $error("write to absent range stored");
    AST_EXT_OFF: assert property (
        @(posedge clk) disable iff (sys_rst)
        (req && !wr && sel == IPTR_SEL_ESPEND && !extended_range_present)
        |=> rdata == 32'h0)
        else $error("absent extended range read not zero");
    AST_EXT_NO_AFF: assert property (
        @(posedge clk) disable iff (sys_rst)
        (req && !wr && sel == IPTR_SEL_ESPEND && !affinity_route_s
         && !affinity_route_ns) |=> rdata == 32'h0)
        else $error("extended bits visible without routing");
    // every read answers once; writes and idle cycles leave the bus at zero
    AST_RVALID: assert property (
        @(posedge clk) disable iff (sys_rst)
        (req && !wr) |=> rvalid)
        else $error("read answer missing");
    AST_RDATA_IDLE: assert property (
        @(posedge clk) disable iff (sys_rst)
        !(req && !wr) |=> (rdata == 32'h0 && !rvalid))
        else $error("answer outside a read");
    AST_UNMAPPED: assert property (
        @(posedge clk) disable iff (sys_rst)
        (req && !wr && sel == IPTR_SEL_NONE) |=> rdata == 32'h0)
        else $error("unmapped read not zero");
    // access control copies are secure-only and gone with security off
    AST_NS_NSAC: assert property (
        @(posedge clk) disable iff (sys_rst)
        (req && !wr && sel == IPTR_SEL_NSAC && nonsecure) |=> rdata == 32'h0)
        else $error("nonsecure read of access control");
    AST_NSAC_SD: assert property (
        @(posedge clk) disable iff (sys_rst)
        (req && !wr && sel == IPTR_SEL_NSAC && security_disable)
        |=> rdata == 32'h0)
        else $error("access control visible with security off");
    AST_NSAC_NS_WRITE: assert property (
        @(posedge clk) disable iff (sys_rst)
        (req && wr && sel == IPTR_SEL_NSAC && nonsecure)
        |=> $stable(nsac_bank[0]))
        else $error("nonsecure write reached access control");
    // target bytes
    AST_SINGLE_PE: assert property (
        @(posedge clk) disable iff (sys_rst)
        (req && !wr && sel == IPTR_SEL_TGT && single_pe) |=> rdata == 32'h0)
        else $error("single pe target read not zero");
    AST_AFF_TGT: assert property (
        @(posedge clk) disable iff (sys_rst)
        (req && !wr && sel == IPTR_SEL_TGT && affinity_route_s
         && affinity_route_ns) |=> rdata == 32'h0)
        else $error("target byte visible under affinity routing");
    AST_BANK_HIGH_PE: assert property (
        @(posedge clk) disable iff (sys_rst)
        (req && !wr && sel == IPTR_SEL_TGT && widx < 16'(BANKED_TGT)
         && !banked_pe_ok) |=> rdata == 32'h0)
        else $error("high pe banked target read not zero");
    AST_BANK_RO: assert property (
        @(posedge clk) disable iff (sys_rst)
        (req && wr && sel == IPTR_SEL_TGT && widx < 16'(BANKED_TGT))
        |=> $stable(tgt_mem[NID-1]))
        else $error("banked target write stored");

    // lane checks on the first shared target word, only when it exists,
    // so the default build with no shared words still elaborates cleanly
    if (NID > BANKED_TGT * 4) begin : g_tgt_chk
        logic lane0_ok;
        assign lane0_ok = tgt_ok(BANKED_TGT * 4);
        AST_TGT_LANE_KEEP: assert property (
            @(posedge clk) disable iff (sys_rst)
            (req && wr && sel == IPTR_SEL_TGT && widx == 16'(BANKED_TGT)
             && !be[0]) |=> $stable(tgt_mem[BANKED_TGT * 4]))
            else $error("disabled target lane changed");
        AST_TGT_LANDS: assert property (
            @(posedge clk) disable iff (sys_rst)
            (req && wr && sel == IPTR_SEL_TGT && widx == 16'(BANKED_TGT)
             && be[0] && lane0_ok && NUM_FIXED == 0)
            |=> tgt_mem[BANKED_TGT * 4] == ($past(wdata[7:0]) & if_mask))
            else $error("target write not visible next cycle");
    end
endmodule : iptr_regs

// [dv/iptr_line_model.sv]
`timescale 1ns/1ps
// far-side interrupt sources: input lines and active state per extended id
module iptr_line_model (
    input  wire logic [1023:0] line_set,
    input  wire logic [1023:0] act_set,
    input  wire logic          clk,
    output logic      [1023:0] ext_line,
    output logic      [1023:0] ext_active
);
    // registered so a line never changes in the same step as a request
    always_ff @(posedge clk) begin
        ext_line   <= line_set;
        ext_active <= act_set;
    end
endmodule : iptr_line_model

// [dv/testbench.sv]
`timescale 1ns/1ps
module testbench import iptr_pkg::*;;
    logic          clk, sys_rst, req, wr, nonsecure, security_disable;
    logic          extended_range_present, affinity_route_s, affinity_route_ns;
    logic          rvalid, single_pe;
    logic [15:0]   addr;
    logic [3:0]    be, pe_num;
    logic [31:0]   wdata, rdata, got, exp, d;
    logic [255:0]  grp_secure, grant_route;
    logic [1023:0] ext_secure, line_set, act_set, ext_line, ext_active;
    logic [1023:0] ext_pending;
    int            fails, checked, seed, idx, j, k;

    iptr_line_model u_iptr_line_model (.clk, .line_set, .act_set,
        .ext_line, .ext_active);
    iptr_regs #(.LINES_COUNT(1)) u_iptr_regs (.clk, .sys_rst, .req, .wr,
        .addr, .be, .wdata, .nonsecure, .pe_num, .security_disable,
        .extended_range_present, .affinity_route_s, .affinity_route_ns,
        .single_pe, .ext_secure, .ext_line, .ext_active, .grp_secure,
        .grant_route, .rdata, .rvalid, .ext_pending);

    // 200 MHz
    always #2.5 clk = ~clk;

    task automatic final_report();
        $display("checked=%0d fails=%0d", checked, fails);
        if (fails == 0 && checked > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : final_report

    task automatic compare(input logic [31:0] g, input logic [31:0] e);
        checked++;
        if (g !== e) begin
            $display("MISMATCH t=%0t got %h exp %h", $time, g, e);
            fails++;
        end
    endtask : compare

    // one request pulse; reads wait a bounded time for rvalid
    task automatic access(input logic w, input logic [15:0] a,
        input logic [3:0] b, input logic [31:0] wd, input logic ns,
        input logic [3:0] p);
        int i;
        @(negedge clk);
        req = 1'b1;
        wr = w;
        addr = a;
        be = b;
        wdata = wd;
        nonsecure = ns;
        pe_num = p;
        @(negedge clk);
        req = 1'b0;
        for (i = 0; i < 4 && !w && rvalid !== 1'b1; i++)
            @(negedge clk);
        if (!w && rvalid !== 1'b1) begin
            fails++;
            final_report();
        end
        got = rdata;
    endtask : access

    task automatic rd(input logic [15:0] a, input logic ns,
        input logic [3:0] p, input logic [31:0] e);
        access(1'b0, a, 4'hF, 32'h0, ns, p);
        compare(got, e);
    endtask : rd

    // main sequence: extended pending bits, targets, access control
    initial begin
        clk = 0; sys_rst = 1; req = 0; wr = 0; addr = 0; be = 0;
        wdata = 0; nonsecure = 0; pe_num = 0; security_disable = 0;
        extended_range_present = 1; affinity_route_s = 1;
        affinity_route_ns = 1; ext_secure = 0; line_set = 0; act_set = 0;
        grp_secure = 0; fails = 0; checked = 0; seed = 59934;
        single_pe = 0; grant_route = 0;
        repeat (12) @(posedge clk);
        @(negedge clk) sys_rst = 0;
        rd(16'h1600, 0, 0, 32'h0);
        idx = $random(seed) & 28;
        j = idx ^ 1;
        k = idx ^ 2;
        act_set[idx] = 1'b1; // active becomes active-and-pending
        access(1, 16'h1600, 4'hF, 32'h1 << idx, 0, 0);
        access(1, 16'h1600, 4'hF, 32'h1 << idx, 0, 0);
        access(1, 16'h1600, 4'hF, 32'h0, 0, 0);
        rd(16'h1600, 0, 0, 32'h1 << idx);
        compare({31'h0, ext_pending[idx]}, 32'h1);
        line_set[j] = 1'b1;
        access(1, 16'h1600, 4'hF, 32'h1 << j, 0, 0);
        line_set[j] = 1'b0;
        exp = (32'h1 << idx) | (32'h1 << j);
        rd(16'h1600, 0, 0, exp);
        ext_secure[idx] = 1'b1;
        ext_secure[k] = 1'b1;
        access(1, 16'h1600, 4'hF, 32'h1 << k, 1, 0);
        rd(16'h1600, 1, 0, 32'h1 << j);
        rd(16'h1600, 0, 0, exp);
        access(1, 16'h1604, 4'hF, 32'hFFFFFFFF, 0, 0);
        rd(16'h1604, 0, 0, 32'h0);
        extended_range_present = 0;
        rd(16'h1600, 0, 0, 32'h0);
        extended_range_present = 1;
        affinity_route_s = 0;
        rd(16'h1600, 0, 0, 32'h1 << j);
        affinity_route_ns = 0;
        d = $random(seed);
        access(1, 16'h0820, 4'h5, d, 0, 0);
        exp = d & 32'h00FF00FF;
        rd(16'h0820, 0, 0, exp);
        d = $random(seed);
        access(1, 16'h0820, 4'h2, d, 0, 0);
        exp = exp | (d & 32'h0000FF00);
        rd(16'h0820, 0, 0, exp);
        grp_secure[33] = 1'b1; // lane 1 turns secure
        access(1, 16'h0820, 4'hF, 32'hFFFFFFFF, 1, 0);
        rd(16'h0820, 1, 0, 32'hFFFF00FF);
        exp = 32'hFFFF00FF | (exp & 32'h0000FF00);
        rd(16'h0820, 0, 0, exp);
        affinity_route_ns = 1;
        rd(16'h0820, 0, 0, exp & 32'h0000FF00);
        affinity_route_ns = 0;
        grant_route[33] = 1'b1; // grant opens the secure lane
        access(1, 16'h0820, 4'h2, 32'h0000A500, 1, 0);
        rd(16'h0820, 1, 0, 32'hFFFFA5FF);
        single_pe = 1;
        rd(16'h0820, 0, 0, 32'h0);
        single_pe = 0;
        access(1, 16'h0800, 4'hF, 32'h0, 0, 1);
        // banked copies answer with the reader's own interface bit
        for (k = 0; k < 9; k++)
            rd(16'h0800, 0, k, k < 8 ? {4{8'h01 << k}} : 32'h0);
        d = $random(seed);
        access(1, 16'h0E00, 4'hF, d, 0, 2);
        rd(16'h0E00, 0, 2, d);
        rd(16'h0E00, 0, 3, 32'h0);
        rd(16'h0E00, 1, 2, 32'h0);
        affinity_route_s = 1;
        affinity_route_ns = 1;
        rd(16'h0820, 0, 0, 32'h0);
        rd(16'h1600, 0, 0, (32'h1 << idx) | (32'h1 << j));
        // mid-run reset must clear the latched bits
        sys_rst = 1;
        repeat (2) @(negedge clk);
        sys_rst = 0;
        rd(16'h1600, 0, 0, 32'h0);
        rd(16'h0004, 0, 0, 32'h0);
        final_report();
    end
endmodule : testbench
